// ### dv/smsp_link_properties.sv
// Concurrent checks on the serial link between the port and its far end.
// Assumes the link interface signals, the port clock and its active-low reset.
`timescale 1ns/1ps
`default_nettype none
module smsp_link_properties (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic dev_sclk_o,
  input wire logic dev_sclk_oe,
  input wire logic dev_mosi_o,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic far_sclk_o,
  input wire logic far_miso_oe,
  input wire logic far_sel_o,
  input wire logic far_sel_oe,
  input wire logic sel_dev,
  input wire logic sel_far
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // --------------------------------------------------------------------
  // Link timing and ownership
  // --------------------------------------------------------------------
  // A half period of the shift clock is at least eight clock cycles
  AST_SCLK_HALF: assert property (
    dev_sclk_oe && $changed(dev_sclk_o) |=> ($stable(dev_sclk_o) || !dev_sclk_oe)[*7])
    else $error("shift clock half period too short");
  // Master data holds for a half period between shift edges
  AST_MOSI_HOLD: assert property (
    dev_mosi_oe && $changed(dev_mosi_o) |=> ($stable(dev_mosi_o) || !dev_mosi_oe)[*7])
    else $error("master data changed too soon");
  // A deselected slave leaves master-in alone
  AST_SLAVE_QUIET: assert property (sel_dev[*4] |-> !dev_miso_oe)
    else $error("deselected slave drives master-in");
  // A master never drives master-in
  AST_MISO_MASTER: assert property (dev_sclk_oe |-> !dev_miso_oe)
    else $error("master drives master-in");
  // Only one slave drives master-in
  AST_MISO_ONE: assert property (!(dev_miso_oe && far_miso_oe))
    else $error("two drivers on master-in");
  // Select low while master releases the shift clock within five cycles
  AST_MM_RELEASE: assert property (
    dev_sclk_oe && !sel_dev ##1 (!sel_dev)[*5] |-> !dev_sclk_oe)
    else $error("shift clock kept after select contention");
  // A selected far slave drives master-in
  AST_FAR_SEL: assert property ((!sel_far)[*4] |-> far_miso_oe)
    else $error("selected far slave silent");
  // Far master clock stands still while its select is high
  AST_FAR_IDLE: assert property (
    (far_sel_oe && far_sel_o)[*4] |-> $stable(far_sclk_o))
    else $error("shift clock moves outside a word");
endmodule
`default_nettype wire

// ### dv/spi_master_slave_port_tb.sv
// Self-checking bench: port and far end joined by the link interface.
// Assumes a 100 MHz clock, classic Wishbone and the far end user port.
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_tb;
  logic        clock_i, nrst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq;
  logic [4:0]  wb_adr;
  logic [31:0] wb_wdat, wb_rdat;
  logic        far_master, far_cpol, far_cpha, far_start, far_done, far_busy, sclk_q;
  logic [7:0]  far_tx, far_rx;
  int          mismatches, checks_done, edges;

  smsp_link_if link ();
  smsp_device i_smsp_device (.clock_i(clock_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq), .link(link));
  smsp_far_end i_smsp_far_end (.clock_i(clock_i), .nrst_i(nrst_i), .master_i(far_master),
    .cpol_i(far_cpol), .cpha_i(far_cpha), .half_m1_i(6'h07), .start_i(far_start),
    .tx_i(far_tx), .rx_o(far_rx), .done_o(far_done), .busy_o(far_busy), .link(link));
  smsp_link_properties i_smsp_link_properties (.clock_i(clock_i), .nrst_i(nrst_i),
    .dev_sclk_o(link.dev_sclk_o), .dev_sclk_oe(link.dev_sclk_oe),
    .dev_mosi_o(link.dev_mosi_o), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_oe(link.dev_miso_oe), .far_sclk_o(link.far_sclk_o),
    .far_miso_oe(link.far_miso_oe), .far_sel_o(link.far_sel_o),
    .far_sel_oe(link.far_sel_oe), .sel_dev(link.sel_dev), .sel_far(link.sel_far));

  // --------------------------------------------------------------------
  // Clock and link edge counter
  // --------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    sclk_q <= link.sclk;
    if (link.sclk !== sclk_q) edges <= edges + 1;
  end

  // --------------------------------------------------------------------
  // Bus, wait and compare tasks
  // --------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= d;
    do begin
      @(posedge clock_i);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(nm, e, q);
  endtask
  // Waits for the far end done pulse or for the interrupt
  task automatic wait_for(input logic far);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (((far ? far_done : irq) !== 1'b1) && n < 5000);
    if (n >= 5000) check("wait", 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clock_i);
    check("irq", {31'h0, e}, {31'h0, irq});
  endtask
  function automatic logic [31:0] ctrl(input logic m, input logic [1:0] md, input logic od,
                                       input logic [2:0] bd, input logic [3:0] fl);
    return {20'h0_0000, fl, bd, od, md[0], md[1], m, 1'b1};
  endfunction

  // --------------------------------------------------------------------
  // Word transfers
  // --------------------------------------------------------------------
  task automatic master_word(input logic [1:0] md, input logic [7:0] dtx, input logic [7:0] ftx);
    int e0;
    @(posedge clock_i);
    far_cpol <= md[1];
    far_cpha <= md[0];
    far_tx   <= ftx;
    wr(smsp_pkg::OFS_CTRL, ctrl(1'b1, md, 1'b0, {1'b0, md}, 4'hE));
    repeat (3) @(posedge clock_i);
    e0 = edges;
    wr(smsp_pkg::OFS_TX, {24'h00_0000, dtx});
    wait_for(1'b1);
    wait_for(1'b0);
    check("edges", 32'h0000_0010, 32'(edges - e0));
    check("idle", {31'h0, md[1]}, {31'h0, link.sclk});
    check("far_rx", {24'h0, dtx}, {24'h0, far_rx});
    rd("stat", smsp_pkg::OFS_STAT, 32'h0000_0001);
    rd("rx", smsp_pkg::OFS_RX, {24'h00_0000, ftx});
    wr(smsp_pkg::OFS_CTRL, ctrl(1'b1, md, 1'b0, 3'h0, 4'hF));
    $display("test master format %0d done", md);
  endtask
  task automatic slave_word(input logic od, input logic [1:0] md, input logic [7:0] dtx,
                            input logic [7:0] ftx);
    wr(smsp_pkg::OFS_CTRL, ctrl(1'b0, md, od, 3'h0, 4'hF));
    wr(smsp_pkg::OFS_TX, {24'h00_0000, dtx});
    far_cpol <= md[1];
    far_cpha <= md[0];
    far_tx   <= ftx;
    @(posedge clock_i);
    far_master <= 1'b1;
    repeat (6) @(posedge clock_i);
    far_start <= 1'b1;
    @(posedge clock_i);
    far_start <= 1'b0;
    wait_for(1'b1);
    check("far_rx", {24'h0, dtx}, {24'h0, far_rx});
    wait_for(1'b0);
    while (far_busy !== 1'b0) @(posedge clock_i);
    rd("stat", smsp_pkg::OFS_STAT, 32'h0000_0001);
    rd("rx", smsp_pkg::OFS_RX, {24'h00_0000, ftx});
    far_master <= 1'b0;
    $display("test slave open-drain %0d done", od);
  endtask

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    {nrst_i, wb_cyc, wb_stb, wb_we, far_master, far_cpol, far_cpha, far_start} = '0;
    {wb_adr, wb_wdat, far_tx} = '0;
    {mismatches, checks_done, edges} = '0;
    sclk_q = 1'b1;
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd("ctrl", smsp_pkg::OFS_CTRL, smsp_pkg::CTRL_RST);
    rd("stat", smsp_pkg::OFS_STAT, 32'h0000_0000);
    wr(5'h14, 32'hFFFF_FFFF);
    rd("unmapped", 5'h14, 32'h0000_0000);
    wr(smsp_pkg::OFS_CTRL, 32'hFFFF_FFF0);
    rd("ctrl", smsp_pkg::OFS_CTRL, 32'h0000_0FF0);
    wr(smsp_pkg::OFS_MASK, 32'h0000_0003);
    $display("test registers done");
    for (int m = 0; m < 4; m++) master_word(m[1:0], 8'hA5 ^ 8'(m), 8'h3C + 8'(m));
    slave_word(1'b0, 2'b01, 8'h96, 8'h5A);
    slave_word(1'b1, 2'b10, 8'h81, 8'hE7);
    // Select contention while master
    wr(smsp_pkg::OFS_CTRL, ctrl(1'b1, 2'b00, 1'b0, 3'h0, 4'hF));
    far_cpol   <= 1'b0;
    far_cpha   <= 1'b0;
    far_master <= 1'b1;
    repeat (6) @(posedge clock_i);
    far_start <= 1'b1;
    @(posedge clock_i);
    far_start <= 1'b0;
    wait_for(1'b0);
    check("sclk_oe", 32'h0, {31'h0, link.dev_sclk_oe});
    wr(smsp_pkg::OFS_MASK, 32'h0000_0000);
    irq_is(1'b0);
    wr(smsp_pkg::OFS_MASK, 32'h0000_0003);
    irq_is(1'b1);
    wait_for(1'b1);
    far_master <= 1'b0;
    repeat (20) @(posedge clock_i);
    rd("stat", smsp_pkg::OFS_STAT, 32'h0000_0002);
    rd("stat", smsp_pkg::OFS_STAT, 32'h0000_0000);
    irq_is(1'b0);
    check("sclk_oe", 32'h1, {31'h0, link.dev_sclk_oe});
    $display("test contention done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    $display("Error watchdog expected finish seen hang");
    complete_run();
  end
endmodule
`default_nettype wire

// ### verilog/smsp_device.sv
// Serial peripheral port, master or slave, with Wishbone registers.
// Assumes a classic Wishbone master and the link interface at the pins.
// Function
// RULE_01: Master makes shift clock at selectable baud.
// RULE_02: One shift clock cycle per bit.
// RULE_03: Master clock toggles only during a word.
// RULE_04: Slave ignores clock while select is high.
// RULE_05: Change data one edge, sample the other.
// RULE_06: Polarity and phase bits set the format.
// RULE_07: Select low enables the slave.
// RULE_08: Select low while master flags multimaster error.
// RULE_09: Flag outputs may drive a slave select.
// RULE_10: Master-out drives as master, receives as slave.
// RULE_11: Master-in receives as master, drives as slave.
// RULE_12: Open-drain bit makes master-in open-drain.
// RULE_13: Only one slave drives master-in.
// RULE_14: Error sets sticky flag, interrupts, releases pins.
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module smsp_device #(
  parameter int WIDTH = smsp_pkg::WORD_W
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  smsp_link_if.dev         link
);
  localparam int CW = $clog2(WIDTH + 1);
  localparam int EW = $clog2(2 * WIDTH + 1);

  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("smsp_device: WIDTH must lie in 2..32");
  end

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [31:0]               ctrl_q;
  logic [smsp_pkg::STAT_W-1:0] stat_q, mask_q;
  logic [WIDTH-1:0]          txbuf_q, rxdata_q;
  logic [WIDTH-1:0]          tx_q, tx_d, rxs_q, rxs_d;
  logic [31:0]               dat_q;
  logic                      ack_q, done_q, sclk_q, sclk_d, sclk_prev_q;
  logic [3:0]                sync1_q, sync2_q;
  logic [smsp_pkg::DIV_W-1:0] div_q;
  logic [CW-1:0]             cnt_q, cnt_d;
  logic [EW-1:0]             ecnt_q, ecnt_d;
  smsp_pkg::smsp_state_e     state_q, state_d;

  // ----------------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------------
  wire logic en        = ctrl_q[smsp_pkg::CTRL_EN];
  wire logic is_master = ctrl_q[smsp_pkg::CTRL_MSTR];
  wire logic cpol      = ctrl_q[smsp_pkg::CTRL_CPOL];
  wire logic cpha      = ctrl_q[smsp_pkg::CTRL_CPHA];
  wire logic od        = ctrl_q[smsp_pkg::CTRL_OD];
  wire logic [smsp_pkg::BAUD_W-1:0] baud = ctrl_q[smsp_pkg::CTRL_BAUD +: smsp_pkg::BAUD_W];
  wire logic mm_q      = stat_q[smsp_pkg::ST_MMERR];

  // Synchronised pins
  wire logic sclk_s = sync2_q[3];
  wire logic sel_s  = sync2_q[2];
  wire logic mosi_s = sync2_q[1];
  wire logic miso_s = sync2_q[0];
  // Slave listens only while selected
  wire logic slv_act = en & ~is_master & ~sel_s;  // RULE_04 RULE_07

  // ----------------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------------
  wire logic wb_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic wb_wr    = wb_req & wb_we_i;
  wire logic hit_ctrl = wb_adr_i[4:2] == smsp_pkg::OFS_CTRL[4:2];
  wire logic hit_tx   = wb_adr_i[4:2] == smsp_pkg::OFS_TX[4:2];
  wire logic hit_rx   = wb_adr_i[4:2] == smsp_pkg::OFS_RX[4:2];
  wire logic hit_stat = wb_adr_i[4:2] == smsp_pkg::OFS_STAT[4:2];
  wire logic hit_mask = wb_adr_i[4:2] == smsp_pkg::OFS_MASK[4:2];
  wire logic rd_stat  = wb_req & ~wb_we_i & hit_stat;
  wire logic busy     = (state_q != smsp_pkg::SMSP_IDLE) | slv_act;
  wire logic [31:0] ctrl_wr = smsp_pkg::byte_merge(ctrl_q, wb_dat_i, wb_sel_i);
  wire logic [31:0] tx_wr   = smsp_pkg::byte_merge(32'(txbuf_q), wb_dat_i, wb_sel_i);
  wire logic [31:0] mask_wr = smsp_pkg::byte_merge(32'(mask_q), wb_dat_i, wb_sel_i);
  wire logic [31:0] rd_val  = hit_ctrl ? ctrl_q :
                              hit_tx   ? 32'(txbuf_q) :
                              hit_rx   ? 32'(rxdata_q) :
                              hit_stat ? 32'({busy, stat_q}) :
                              hit_mask ? 32'(mask_q) : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Shift engine events
  // ----------------------------------------------------------------------
  // Master clock divider runs only during a word
  wire logic run   = state_q == smsp_pkg::SMSP_RUN;
  wire logic tick  = run & (div_q == smsp_pkg::half_m1(baud));  // RULE_01
  wire logic rise  = sclk_s & ~sclk_prev_q;
  wire logic fall  = ~sclk_s & sclk_prev_q;
  wire logic lead_ev  = is_master ? tick & (sclk_q == cpol)
                                  : slv_act & (cpol ? fall : rise);
  wire logic trail_ev = is_master ? tick & (sclk_q != cpol)
                                  : slv_act & (cpol ? rise : fall);
  wire logic samp_ev  = cpha ? trail_ev : lead_ev;  // RULE_05 RULE_06
  wire logic chg_ev   = cpha ? lead_ev : trail_ev;  // RULE_05 RULE_06
  wire logic act      = is_master ? run : slv_act;
  wire logic din      = is_master ? miso_s : mosi_s;  // RULE_10 RULE_11
  wire logic m_last   = tick & (ecnt_q == EW'(2 * WIDTH - 1));  // RULE_02
  wire logic s_last   = ~is_master & samp_ev & (cnt_q == CW'(WIDTH - 1));
  wire logic start    = wb_wr & hit_tx & en & is_master & ~run & ~mm_q;
  wire logic mm_set   = en & is_master & ~sel_s;  // RULE_08
  wire logic [smsp_pkg::STAT_W-1:0] stat_set = {mm_set, done_q};

  // Next state of the shift engine
  always_comb begin
    state_d = state_q;
    sclk_d  = sclk_q;
    ecnt_d  = ecnt_q;
    cnt_d   = cnt_q;
    tx_d    = tx_q;
    rxs_d   = rxs_q;
    unique case (state_q)
      smsp_pkg::SMSP_IDLE: begin
        sclk_d = cpol;  // RULE_03
        ecnt_d = '0;
        if (start) begin
          state_d = smsp_pkg::SMSP_RUN;
        end
      end
      smsp_pkg::SMSP_RUN: begin
        if (tick) begin
          sclk_d = ~sclk_q;  // RULE_03
          ecnt_d = ecnt_q + 1'b1;
        end
        if (m_last | mm_q | ~en | ~is_master) begin
          state_d = smsp_pkg::SMSP_IDLE;  // RULE_14
        end
      end
      default: begin
        state_d = smsp_pkg::SMSP_IDLE;
      end
    endcase
    if (~act | s_last) begin
      cnt_d = '0;
    end else if (samp_ev) begin
      cnt_d = cnt_q + 1'b1;
    end
    // Shift out skips the change edge that comes before the first sample
    if (start) begin
      tx_d = tx_wr[WIDTH-1:0];
    end else if (~is_master & (~slv_act | s_last)) begin
      tx_d = txbuf_q;
    end else if (chg_ev & act & (cnt_q != '0)) begin
      tx_d = {tx_q[WIDTH-2:0], 1'b0};  // RULE_05
    end
    if (samp_ev & act) begin
      rxs_d = {rxs_q[WIDTH-2:0], din};  // RULE_05
    end
  end

  // ----------------------------------------------------------------------
  // Clocked processes
  // ----------------------------------------------------------------------
  // Two-stage pin synchronisers and clock edge history
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q     <= 4'hF;
      sync2_q     <= 4'hF;
      sclk_prev_q <= 1'b1;
    end else begin
      sync1_q     <= {link.sclk, link.sel_dev, link.mosi, link.miso};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sclk_s;
    end
  end

  // Shift engine
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= smsp_pkg::SMSP_IDLE;
      sclk_q  <= 1'b0;
      ecnt_q  <= '0;
      cnt_q   <= '0;
      tx_q    <= '0;
      rxs_q   <= '0;
      div_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      sclk_q  <= sclk_d;
      ecnt_q  <= ecnt_d;
      cnt_q   <= cnt_d;
      tx_q    <= tx_d;
      rxs_q   <= rxs_d;
      div_q   <= (~run | tick) ? '0 : div_q + 1'b1;
      done_q  <= (run & m_last) | s_last;
    end
  end

  // Software registers; a set in the clearing read wins
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q   <= smsp_pkg::CTRL_RST;
      mask_q   <= '0;
      txbuf_q  <= '0;
      rxdata_q <= '0;
      stat_q   <= '0;
    end else begin
      if (wb_wr & hit_ctrl) ctrl_q <= ctrl_wr & smsp_pkg::CTRL_WMASK;
      if (wb_wr & hit_mask) mask_q <= mask_wr[smsp_pkg::STAT_W-1:0];
      if (wb_wr & hit_tx) txbuf_q <= tx_wr[WIDTH-1:0];
      if (done_q) rxdata_q <= rxs_q;
      stat_q <= (stat_q & ~{smsp_pkg::STAT_W{rd_stat}}) | stat_set;  // RULE_14
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= wb_req;
      dat_q <= (wb_req & ~wb_we_i) ? rd_val : dat_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = dat_q;
  assign irq_o            = |(stat_q & mask_q);  // RULE_14
  assign link.dev_sclk_o  = sclk_q;
  assign link.dev_sclk_oe = en & is_master & ~mm_q;  // RULE_01 RULE_14
  assign link.dev_mosi_o  = tx_q[WIDTH-1];
  assign link.dev_mosi_oe = en & is_master & ~mm_q;  // RULE_10 RULE_14
  assign link.dev_miso_o  = tx_q[WIDTH-1];
  // Slave drives master-in only while selected; open-drain drives lows only
  assign link.dev_miso_oe = slv_act & (~od | ~tx_q[WIDTH-1]);  // RULE_11 RULE_12 RULE_13
  assign link.dev_flag_o  = ctrl_q[smsp_pkg::CTRL_FLAG +: smsp_pkg::FLAG_W];  // RULE_09
endmodule
`default_nettype wire

// ### verilog/smsp_far_end.sv
// Far end of the serial link: a master or slave peer with a plain user port.
// Assumes the link interface and a user that pulses start_i while idle.
`timescale 1ns/1ps
`default_nettype none
module smsp_far_end #(
  parameter int WIDTH = smsp_pkg::WORD_W
) (
  input  wire logic                       clock_i,
  input  wire logic                       nrst_i,
  input  wire logic                       master_i,
  input  wire logic                       cpol_i,
  input  wire logic                       cpha_i,
  input  wire logic [smsp_pkg::DIV_W-1:0] half_m1_i,
  input  wire logic                       start_i,
  input  wire logic [WIDTH-1:0]           tx_i,
  output logic      [WIDTH-1:0]           rx_o,
  output logic                            done_o,
  output logic                            busy_o,
  smsp_link_if.far                        link
);
  localparam int CW = $clog2(WIDTH + 1);
  localparam int EW = $clog2(2 * WIDTH + 1);

  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("smsp_far_end: WIDTH must lie in 2..32");
  end

  logic [3:0]                 sync1_q, sync2_q;
  logic                       sclk_prev_q, sclk_q, done_q;
  logic [smsp_pkg::DIV_W-1:0] div_q;
  logic [CW-1:0]              cnt_q;
  logic [EW-1:0]              ecnt_q;
  logic [WIDTH-1:0]           tx_q, rxs_q;
  smsp_pkg::smsp_state_e      state_q;

  // ----------------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------------
  wire logic sclk_s   = sync2_q[3];
  wire logic sel_s    = sync2_q[2];
  wire logic run      = state_q == smsp_pkg::SMSP_RUN;
  wire logic idle     = state_q == smsp_pkg::SMSP_IDLE;
  wire logic tick     = ~idle & (div_q == half_m1_i);
  wire logic rise     = sclk_s & ~sclk_prev_q;
  wire logic fall     = ~sclk_s & sclk_prev_q;
  wire logic slv_act  = ~master_i & ~sel_s;  // RULE_07
  wire logic lead_ev  = master_i ? run & tick & (sclk_q == cpol_i)
                                 : slv_act & (cpol_i ? fall : rise);
  wire logic trail_ev = master_i ? run & tick & (sclk_q != cpol_i)
                                 : slv_act & (cpol_i ? rise : fall);
  wire logic samp_ev  = cpha_i ? trail_ev : lead_ev;  // RULE_05
  wire logic chg_ev   = cpha_i ? lead_ev : trail_ev;  // RULE_05
  wire logic act      = master_i ? run : slv_act;
  wire logic din      = master_i ? sync2_q[0] : sync2_q[1];
  wire logic m_last   = run & tick & (ecnt_q == EW'(2 * WIDTH - 1));  // RULE_02
  wire logic s_last   = ~master_i & samp_ev & (cnt_q == CW'(WIDTH - 1));
  // Word with the bit of this edge, so rx_o is valid with done_o
  wire logic [WIDTH-1:0] rxs_nx = (samp_ev & act) ? {rxs_q[WIDTH-2:0], din} : rxs_q;

  // Synchronisers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q     <= 4'hF;
      sync2_q     <= 4'hF;
      sclk_prev_q <= 1'b1;
    end else begin
      sync1_q     <= {link.sclk, link.sel_far, link.mosi, link.miso};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sclk_s;
    end
  end

  // Master sequence: select, word, half period tail, release
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= smsp_pkg::SMSP_IDLE;
      sclk_q  <= 1'b0;
      ecnt_q  <= '0;
      div_q   <= '0;
    end else begin
      div_q <= (idle | tick) ? '0 : div_q + 1'b1;
      unique case (state_q)
        smsp_pkg::SMSP_IDLE: begin
          sclk_q <= cpol_i;
          ecnt_q <= '0;
          if (start_i & master_i) state_q <= smsp_pkg::SMSP_RUN;
        end
        smsp_pkg::SMSP_RUN: begin
          if (tick) sclk_q <= ~sclk_q;
          if (tick) ecnt_q <= ecnt_q + 1'b1;
          if (m_last) state_q <= smsp_pkg::SMSP_TAIL;
        end
        smsp_pkg::SMSP_TAIL: begin
          if (tick) state_q <= smsp_pkg::SMSP_IDLE;
        end
        default: begin
          state_q <= smsp_pkg::SMSP_IDLE;
        end
      endcase
    end
  end

  // Shift registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q  <= '0;
      tx_q   <= '0;
      rxs_q  <= '0;
      done_q <= 1'b0;
      rx_o   <= '0;
    end else begin
      cnt_q <= (~act | s_last) ? '0 : cnt_q + CW'(samp_ev);
      if ((start_i & idle) | (~master_i & (~slv_act | s_last))) begin
        tx_q <= tx_i;
      end else if (chg_ev & act & (cnt_q != '0)) begin
        tx_q <= {tx_q[WIDTH-2:0], 1'b0};
      end
      rxs_q  <= rxs_nx;
      done_q <= m_last | s_last;
      if (m_last | s_last) rx_o <= rxs_nx;
    end
  end

  // Outputs
  assign done_o           = done_q;
  assign busy_o           = ~idle | slv_act;
  assign link.far_sclk_o  = sclk_q;
  assign link.far_sclk_oe = master_i;
  assign link.far_sel_o   = idle;  // RULE_07
  assign link.far_sel_oe  = master_i;
  assign link.far_mosi_o  = tx_q[WIDTH-1];
  assign link.far_mosi_oe = master_i;
  assign link.far_miso_o  = tx_q[WIDTH-1];
  assign link.far_miso_oe = slv_act;  // RULE_13
endmodule
`default_nettype wire

// ### verilog/smsp_link_if.sv
// Serial link between the port and its far end.
// Assumes sclk, mosi, miso and sel_dev have pull-ups: such a line is low while any end drives low.
`timescale 1ns/1ps
`default_nettype none
interface smsp_link_if;
  logic       dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe;
  logic       dev_miso_o, dev_miso_oe;
  logic [3:0] dev_flag_o;
  logic       far_sclk_o, far_sclk_oe, far_mosi_o, far_mosi_oe;
  logic       far_miso_o, far_miso_oe, far_sel_o, far_sel_oe;
  logic       sclk, mosi, miso, sel_dev, sel_far;

  // Wired lines with pull-ups
  assign sclk    = ~((dev_sclk_oe & ~dev_sclk_o) | (far_sclk_oe & ~far_sclk_o));
  assign mosi    = ~((dev_mosi_oe & ~dev_mosi_o) | (far_mosi_oe & ~far_mosi_o));
  assign miso    = ~((dev_miso_oe & ~dev_miso_o) | (far_miso_oe & ~far_miso_o));
  assign sel_dev = ~(far_sel_oe & ~far_sel_o);
  assign sel_far = dev_flag_o[0];  // Flag 0 selects the far end

  modport dev (output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe,
               output dev_miso_o, dev_miso_oe, dev_flag_o,
               input  sclk, mosi, miso, sel_dev);
  modport far (output far_sclk_o, far_sclk_oe, far_mosi_o, far_mosi_oe,
               output far_miso_o, far_miso_oe, far_sel_o, far_sel_oe,
               input  sclk, mosi, miso, sel_far);
endinterface
`default_nettype wire

// ### verilog/smsp_pkg.sv
// Shared constants, register map and helpers of the serial peripheral port.
// Assumes both link ends and the register bus use these names.
package smsp_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int WORD_W = 8;
  localparam int DIV_W  = 6;
  localparam int BAUD_W = 3;
  localparam int FLAG_W = 4;
  localparam int STAT_W = 2;
  // Low bits of a half period minus one: each baud step adds eight clock cycles
  localparam logic [2:0] BAUD_LOW = 3'h7;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_TX   = 5'h04;
  localparam logic [4:0] OFS_RX   = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_MASK = 5'h10;

  // Control field positions
  localparam int CTRL_EN   = 0;
  localparam int CTRL_MSTR = 1;
  localparam int CTRL_CPOL = 2;
  localparam int CTRL_CPHA = 3;
  localparam int CTRL_OD   = 4;
  localparam int CTRL_BAUD = 5;
  localparam int CTRL_FLAG = 8;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0F00;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0FFF;

  // Status field positions
  localparam int ST_DONE  = 0;
  localparam int ST_MMERR = 1;
  localparam int ST_BUSY  = 2;

  // ----------------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SMSP_IDLE = 3'b001,
    SMSP_RUN  = 3'b010,
    SMSP_TAIL = 3'b100
  } smsp_state_e;

  // Half period of the shift clock minus one, in clock cycles
  function automatic logic [DIV_W-1:0] half_m1(input logic [BAUD_W-1:0] baud);
    return {baud, BAUD_LOW};
  endfunction

  // Merge new bytes into an old word under byte enables
  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction
endpackage
